// ---- design/psc_pkg.sv ----
// constants, pin carrier and state encoding shared by the serial port block
// assumes an 8-bit classic wishbone register bus and a 50 MHz mclk
package psc_pkg;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [11:0] IDX_DATA = 12'hF60;
  localparam logic [11:0] IDX_CTRL = 12'hF61;
  localparam logic [11:0] IDX_STAT = 12'hF62;
  localparam logic [11:0] IDX_MODE = 12'hF63;
  localparam logic [11:0] IDX_DIVH = 12'hF66;
  localparam logic [11:0] IDX_DIVL = 12'hF67;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned CTL_IRQE = 7;
  localparam int unsigned CTL_STR = 6;
  localparam int unsigned CTL_TIMER = 5;
  localparam int unsigned CTL_PHASE = 4;
  localparam int unsigned CTL_IDLE = 3;
  localparam int unsigned CTL_WOR = 2;
  localparam int unsigned CTL_MASTER = 1;
  localparam int unsigned CTL_EN = 0;
  localparam int unsigned ST_IRQ = 7;
  localparam int unsigned ST_OVR = 6;
  localparam int unsigned ST_COL = 5;
  localparam int unsigned ST_ACT = 1;
  localparam int unsigned ST_SEL = 0;
  localparam int unsigned MODE_LEN_HI = 4;
  localparam int unsigned MODE_LEN_LO = 2;
  localparam int unsigned MODE_SELECT_PIN_DIRECTION = 1;
  localparam int unsigned MODE_SSV = 0;

  // ****************************************************************
  // reset values and full character length
  // ****************************************************************
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [4:0] MODE_RST = 5'h00;
  localparam logic [7:0] DIV_RST = 8'hFF;
  localparam logic SEL_RST = 1'b1;
  localparam logic [3:0] FULL_CHAR = 4'h8;

  typedef enum logic [1:0] {
    PSC_IDLE = 2'b00,
    PSC_MXFER = 2'b01,
    PSC_SXFER = 2'b10
  } psc_state_e;

  typedef struct packed {
    logic sck;
    logic ss_n;
    logic mosi;
    logic miso;
  } psc_pins_s;

endpackage

// ---- design/psc_divisor.sv ----
// reload divisor: counts mclk cycles down from the 16-bit reload value
// assumes run is held low to restart the count from the reload value
`timescale 1ns/1ps
`default_nettype none
module psc_divisor (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic run,
  input wire logic [15:0] reload,
  output logic tick_q
);
  logic [15:0] cnt_q;

  // ****************************************************************
  // down counter, one tick per reload period
  // ****************************************************************
  // a reload of 0 or 1 ticks every cycle rather than stalling
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 16'hFFFF;
      tick_q <= 1'b0;
    end else if (!run) begin
      cnt_q <= reload;
      tick_q <= 1'b0;
    end else if (cnt_q <= 16'h0001) begin
      cnt_q <= reload;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q - 16'h0001;
      tick_q <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ---- design/psc_core.sv ----
// serial peripheral port: registers, transfer engine and pin drivers
// assumes pins are already synchronous to mclk; the bench resolves the wires
`timescale 1ns/1ps
`default_nettype none
module psc_core
  import psc_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [13:0] wb_adr_i,
  input wire logic wb_sel_i,
  input wire logic [7:0] wb_dat_i,
  output logic [7:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire psc_pkg::psc_pins_s pins_i,
  output psc_pkg::psc_pins_s pins_o,
  output psc_pkg::psc_pins_s pins_oe
);
  import psc_pkg::*;

  psc_state_e st_q;
  logic [7:0] ctl_q;
  logic [4:0] mode_q;
  logic [7:0] divh_q;
  logic [7:0] divl_q;
  logic [7:0] sr_q;
  logic [3:0] cnt_q;
  logic dout_q;
  logic rxb_q;
  logic lvl_q;
  logic sck_prev_q;
  logic done_q;
  logic irq_q;
  logic ovr_q;
  logic col_q;
  logic sel_q;
  logic tick;

  // ****************************************************************
  // decode
  // ****************************************************************
  logic en;
  logic master;
  logic phase;
  logic busy;
  logic req;
  logic wr;
  logic [11:0] idx;
  logic [3:0] len;
  logic [7:0] stat;
  logic timer_run;
  logic in_bit;
  logic s_lead;
  logic s_trail;
  logic lead;
  logic trail;
  logic wr_data;

  assign en = ctl_q[CTL_EN];
  assign master = ctl_q[CTL_MASTER];
  assign phase = ctl_q[CTL_PHASE];
  assign busy = (st_q != PSC_IDLE);
  assign req = wb_cyc_i & wb_stb_i;
  assign idx = wb_adr_i[13:2];
  // writes land on the edge where the master sees ack
  assign wr = req & wb_we_i & wb_sel_i & wb_ack_o;
  assign wr_data = wr & (idx == IDX_DATA);
  // code zero stands for a full byte
  assign len = (mode_q[MODE_LEN_HI:MODE_LEN_LO] == 3'h0) ? FULL_CHAR :
               {1'b0, mode_q[MODE_LEN_HI:MODE_LEN_LO]};
  // reserved status bits stay zero
  assign stat = {irq_q, ovr_q, col_q, 3'h0, busy, sel_q};
  // timer only runs while the port is off
  assign timer_run = ~en & ctl_q[CTL_TIMER];
  assign in_bit = master ? pins_i.miso : pins_i.mosi;
  assign s_lead = (st_q == PSC_SXFER) && (pins_i.sck != sck_prev_q) && ((pins_i.sck ^ ctl_q[CTL_IDLE]) == 1'b1);
  assign s_trail = (st_q == PSC_SXFER) && (pins_i.sck != sck_prev_q) && ((pins_i.sck ^ ctl_q[CTL_IDLE]) == 1'b0);
  assign lead = (st_q == PSC_MXFER) ? (tick & ~lvl_q) : s_lead;
  assign trail = (st_q == PSC_MXFER) ? (tick & lvl_q) : s_trail;

  // each tick is half a bit period, so the rate is mclk over twice the reload
  psc_divisor u_div (
    .mclk(mclk),
    .rstn(rstn),
    .run((st_q == PSC_MXFER) | timer_run),
    .reload({divh_q, divl_q}),
    .tick_q(tick)
  );

  // ****************************************************************
  // wishbone slave, one wait state
  // ****************************************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 8'h00;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      case (idx)
        IDX_DATA: wb_dat_o <= sr_q;
        IDX_CTRL: wb_dat_o <= ctl_q;
        IDX_STAT: wb_dat_o <= stat;
        IDX_MODE: wb_dat_o <= {3'h0, mode_q};
        IDX_DIVH: wb_dat_o <= divh_q;
        IDX_DIVL: wb_dat_o <= divl_q;
        default: wb_dat_o <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctl_q <= CTRL_RST;
      mode_q <= MODE_RST;
      divh_q <= DIV_RST;
      divl_q <= DIV_RST;
    end else begin
      if (wr && idx == IDX_CTRL) begin
        // the start-request bit is a strobe and never stores
        ctl_q <= {wb_dat_i[7], 1'b0, wb_dat_i[5:0]};
      end
      if (wr && idx == IDX_MODE) begin
        mode_q <= wb_dat_i[4:0];
      end
      if (wr && idx == IDX_DIVH) begin
        divh_q <= wb_dat_i;
      end
      if (wr && idx == IDX_DIVL) begin
        divl_q <= wb_dat_i;
      end
    end
  end

  // ****************************************************************
  // status flags: a hardware set wins over a clear in the same cycle
  // ****************************************************************
  logic clr_irq;
  logic clr_ovr;
  logic clr_col;
  logic set_irq;
  logic set_ovr;
  logic set_col;

  assign clr_irq = wr && idx == IDX_STAT && wb_dat_i[ST_IRQ];
  assign clr_ovr = wr && idx == IDX_STAT && wb_dat_i[ST_OVR];
  assign clr_col = wr && idx == IDX_STAT && wb_dat_i[ST_COL];
  assign set_irq = done_q | (tick & timer_run) |
                   (wr && idx == IDX_CTRL && wb_dat_i[CTL_STR]);
  assign set_ovr = wr_data & busy;
  // another master pulled our select input low
  assign set_col = en & master & ~mode_q[MODE_SELECT_PIN_DIRECTION] & ~pins_i.ss_n;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq_q <= 1'b0;
    end else if (set_irq) begin
      irq_q <= 1'b1;
    end else if (clr_irq) begin
      irq_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ovr_q <= 1'b0;
    end else if (set_ovr) begin
      ovr_q <= 1'b1;
    end else if (clr_ovr) begin
      ovr_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      col_q <= 1'b0;
    end else if (set_col) begin
      col_q <= 1'b1;
    end else if (clr_col) begin
      col_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sel_q <= SEL_RST;
      irq_o <= 1'b0;
    end else begin
      if (en && !master) begin
        sel_q <= pins_i.ss_n;
      end
      irq_o <= irq_q & ctl_q[CTL_IRQE];
    end
  end

  // ****************************************************************
  // transfer engine
  // ****************************************************************
  // transmit data leaves from bit 7, received bits enter at bit 0, so a short
  // character ends up right justified after len shifts
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q <= PSC_IDLE;
      sr_q <= 8'h00;
      cnt_q <= 4'h0;
      dout_q <= 1'b0;
      rxb_q <= 1'b0;
      lvl_q <= 1'b0;
      sck_prev_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      sck_prev_q <= pins_i.sck;
      case (st_q)
        PSC_IDLE: begin
          lvl_q <= 1'b0;
          if (wr_data) begin
            sr_q <= wb_dat_i;
            dout_q <= wb_dat_i[7];
            if (en && master) begin
              st_q <= PSC_MXFER;
              cnt_q <= len;
            end
          end else if (en && !master && !pins_i.ss_n) begin
            st_q <= PSC_SXFER;
            dout_q <= sr_q[7];
          end
        end
        PSC_MXFER: begin
          if (!en || !master) begin
            st_q <= PSC_IDLE;
          end else if (tick) begin
            lvl_q <= ~lvl_q;
            if (lvl_q && cnt_q == 4'h1) begin
              st_q <= PSC_IDLE;
              done_q <= 1'b1;
            end
            if (lvl_q) begin
              cnt_q <= cnt_q - 4'h1;
            end
          end
        end
        PSC_SXFER: begin
          if (!en || master) begin
            st_q <= PSC_IDLE;
          end else if (pins_i.ss_n) begin
            st_q <= PSC_IDLE;
            done_q <= 1'b1;
          end
        end
        default: st_q <= PSC_IDLE;
      endcase
      // phase 0 samples on the leading edge, phase 1 launches on it
      if (lead) begin
        if (phase) begin
          dout_q <= sr_q[7];
        end else begin
          rxb_q <= in_bit;
        end
      end
      if (trail) begin
        if (phase) begin
          sr_q <= {sr_q[6:0], in_bit};
        end else begin
          sr_q <= {sr_q[6:0], rxb_q};
          dout_q <= sr_q[6];
        end
      end
    end
  end

  // ****************************************************************
  // pin drivers
  // ****************************************************************
  logic [3:0] drv;
  logic [3:0] val;
  logic [3:0] o_q;
  logic [3:0] oe_q;

  assign val = {lvl_q ^ ctl_q[CTL_IDLE], mode_q[MODE_SSV], dout_q, dout_q};
  // select is an output only for a master
  assign drv = {en & master, en & master & mode_q[MODE_SELECT_PIN_DIRECTION], en & master,
                en & ~master & ~pins_i.ss_n};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          o_q[gi] <= 1'b0;
          oe_q[gi] <= 1'b0;
        end else begin
          o_q[gi] <= val[gi];
          // in wire-or mode a high level is left to the pull-up
          oe_q[gi] <= drv[gi] & (~ctl_q[CTL_WOR] | ~val[gi]);
        end
      end
    end
  endgenerate

  assign pins_o = o_q;
  assign pins_oe = oe_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_ovr;
    @(posedge mclk) disable iff (!rstn) (wr_data && busy) |=> ovr_q;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not flagged");

  property p_timer_off;
    @(posedge mclk) disable iff (!rstn) en |-> ##1 !(tick && st_q == PSC_IDLE && $past(st_q) == PSC_IDLE);
  endproperty
  a_timer_off: assert property (p_timer_off) else $error("timer ticked while enabled");

  property p_idle_lvl;
    @(posedge mclk) disable iff (!rstn) (st_q == PSC_IDLE && en && master) |=> pins_o.sck == $past(ctl_q[CTL_IDLE]);
  endproperty
  a_idle_lvl: assert property (p_idle_lvl) else $error("idle clock level wrong");

  property p_wor;
    @(posedge mclk) disable iff (!rstn) ctl_q[CTL_WOR] |=> !(pins_oe.sck && pins_o.sck) && !(pins_oe.ss_n && pins_o.ss_n);
  endproperty
  a_wor: assert property (p_wor) else $error("wire-or pin driven high");

  property p_ss_out;
    @(posedge mclk) disable iff (!rstn) (en && master && mode_q[MODE_SELECT_PIN_DIRECTION] && !ctl_q[CTL_WOR])
      |=> pins_oe.ss_n && pins_o.ss_n == $past(mode_q[MODE_SSV]);
  endproperty
  a_ss_out: assert property (p_ss_out) else $error("select pin not driven");

  property p_ss_slave;
    @(posedge mclk) disable iff (!rstn) !master |=> !pins_oe.ss_n;
  endproperty
  a_ss_slave: assert property (p_ss_slave) else $error("slave drove select");

  property p_col;
    @(posedge mclk) disable iff (!rstn) (en && master && !mode_q[MODE_SELECT_PIN_DIRECTION] && !pins_i.ss_n) |=> col_q;
  endproperty
  a_col: assert property (p_col) else $error("collision missed");

  property p_w1c;
    @(posedge mclk) disable iff (!rstn) (clr_ovr && !set_ovr) |=> !ovr_q;
  endproperty
  a_w1c: assert property (p_w1c) else $error("overrun not cleared");

  property p_sel;
    @(posedge mclk) disable iff (!rstn) (en && !master) |=> stat[ST_SEL] == $past(pins_i.ss_n);
  endproperty
  a_sel: assert property (p_sel) else $error("select level wrong");

  property p_done;
    @(posedge mclk) disable iff (!rstn) done_q |=> irq_q;
  endproperty
  a_done: assert property (p_done) else $error("no request after character");

  property p_act;
    @(posedge mclk) disable iff (!rstn) (wr_data && !busy && en && master) |=> stat[ST_ACT];
  endproperty
  a_act: assert property (p_act) else $error("active bit not set");

endmodule
`default_nettype wire

// ---- tb/psc_far_dev.sv ----
// far-side serial slave model that answers the port in master role
// assumes resolved wires with pull-ups; idle level and phase come from the bench
`timescale 1ns/1ps
`default_nettype none
module psc_far_dev (
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic cpol,
  input wire logic phase,
  input wire logic [7:0] tx,
  output logic miso,
  output logic miso_oe,
  output logic [7:0] rx,
  output int nbits
);
  logic [7:0] sh;
  // released line falls back to the pull-up
  assign miso_oe = !ss_n;
  initial begin
    miso = 1'b1;
    rx = 8'h00;
    nbits = 0;
    sh = 8'h00;
  end
  // frame opens on select; phase 0 needs the first bit out before any edge
  always @(negedge ss_n) begin
    rx = 8'h00;
    nbits = 0;
    sh = tx;
    miso = tx[7];
  end
  always @(sck) begin
    if (!ss_n && ((sck != cpol) ^ phase)) begin
      rx = {rx[6:0], mosi};
      nbits++;
    end else if (!ss_n && phase) begin
      miso = sh[7];
      sh = sh << 1;
    end else if (!ss_n) begin
      sh = sh << 1;
      miso = sh[7];
    end
  end
endmodule
`default_nettype wire

// ---- tb/psc_core_bench.sv ----
// self-checking bench for the serial port block with a far-side slave model
// assumes the register map and timing of psc_pkg; all pins pulled up
`timescale 1ns/1ps
`default_nettype none
module psc_core_bench;
  import psc_pkg::*;
  logic mclk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, sel = 0, sel_v = 1, tb_ss = 0;
  logic cp = 0, ph = 0, wor_on = 0, irq, sck_p = 0, ack, tb_sck = 1, tb_mosi = 1;
  logic [13:0] adr = '0;
  logic [7:0] dat = '0, rd, ptx = '0, mtx, f_miso_rx, wdo, srx;
  logic [15:0] cnt = '0, gap = '0, rl = 16'h0002;
  logic [31:0] rnd = 32'h19328662;
  logic f_miso, f_oe;
  int f_n, comparisons = 0, miscompares = 0;
  psc_pins_s po, poe, pw;
  // ****
  // wires, design and far side
  // ****
  // undriven sck and mosi follow the bench's own master drive, which idles high like the pull-ups
  assign pw = {poe.sck ? po.sck : tb_sck, poe.ss_n ? po.ss_n : !tb_ss, poe.mosi ? po.mosi : tb_mosi,
    poe.miso ? po.miso : (f_oe ? f_miso : 1'b1)};
  always #10 mclk = ~mclk;
  psc_core i_dut (.mclk(mclk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wdo), .wb_ack_o(ack),
    .irq_o(irq), .pins_i(pw), .pins_o(po), .pins_oe(poe));
  psc_far_dev i_far (.sck(pw.sck), .ss_n(pw.ss_n), .mosi(pw.mosi), .cpol(cp), .phase(ph),
    .tx(ptx), .miso(f_miso), .miso_oe(f_oe), .rx(f_miso_rx), .nbits(f_n));
  // mclk cycles between sck toggles
  always @(posedge mclk) begin
    cnt <= (po.sck != sck_p) ? 16'h0000 : cnt + 16'h0001;
    if (po.sck != sck_p) gap <= cnt + 16'h0001;
    sck_p <= po.sck;
  end
  always @(negedge mclk) if (wor_on) chk({12'h000, po & poe}, 16'h0000);
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // request stands until the rising edge that sees ack; read data is taken at that same edge
  task automatic wb(input logic w, input logic [11:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= sel_v;
    adr <= {idx, 2'b00};
    dat <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    rd = wdo;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 40) chk(16'h0000, 16'h0001);
  endtask
  task automatic rdc(input logic [11:0] idx, input logic [7:0] e);
    wb(1'b0, idx, 8'h00);
    chk(rd, e);
  endtask
  task automatic xfer(input logic [7:0] ctl, input logic [2:0] len, input logic ov);
    int nb, n;
    logic [7:0] m;
    nb = (len == 3'd0) ? 8 : len;
    m = 8'hFF >> (8 - nb);
    rnd = nx(rnd);
    mtx = rnd[7:0];
    ptx = rnd[15:8];
    rl = {14'h0000, rnd[17:16]} + 16'h0002;
    wb(1'b1, IDX_DIVL, rl[7:0]);
    wb(1'b1, IDX_MODE, {3'b000, len, 2'b11});
    wb(1'b1, IDX_CTRL, ctl);
    cp = ctl[3];
    ph = ctl[4];
    wb(1'b1, IDX_MODE, {3'b000, len, 2'b10});
    wor_on = ctl[2];
    wb(1'b1, IDX_DATA, mtx);
    wb(1'b0, IDX_STAT, 8'h00);
    chk(rd[1], 1'b1);
    if (ov) wb(1'b1, IDX_DATA, ~mtx);
    n = 0;
    do begin
      wb(1'b0, IDX_STAT, 8'h00);
      n++;
    end while (rd[1] !== 1'b0 && n < 200);
    // the last sck edge and the registered irq land up to two edges after active clears
    repeat (2) @(posedge mclk);
    wor_on = 0;
    chk(pw.sck, cp);
    chk(gap, rl);
    chk(irq, ctl[7]);
    chk(f_miso_rx, mtx >> (8 - nb));
    chk(f_n, nb);
    wb(1'b0, IDX_DATA, 8'h00);
    chk(rd & m, ptx >> (8 - nb));
    wb(1'b1, IDX_STAT, 8'h00);
    rdc(IDX_STAT, {1'b1, ov, 6'b000001});
    wb(1'b1, IDX_STAT, 8'hE0);
    rdc(IDX_STAT, 8'h01);
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    miscompares++;
    test_done;
  end
  // ****
  // main sequence
  // ****
  initial begin
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    rdc(IDX_CTRL, 8'h00);
    rdc(IDX_STAT, 8'h01);
    rdc(IDX_MODE, 8'h00);
    rdc(IDX_DIVH, 8'hFF);
    rdc(IDX_DIVL, 8'hFF);
    rdc(12'hF64, 8'h00);
    wb(1'b1, IDX_MODE, 8'hFF);
    rdc(IDX_MODE, 8'h1F);
    sel_v = 0;
    wb(1'b1, IDX_CTRL, 8'h01);
    sel_v = 1;
    rdc(IDX_CTRL, 8'h00);
    wb(1'b1, IDX_DIVH, 8'h00);
    rdc(IDX_DIVH, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      rnd = nx(rnd);
      xfer({rnd[0], 2'b00, rnd[1], rnd[2], i == 5, 2'b11}, i[2:0], i == 3);
    end
    $display("test transfers done");
    wb(1'b1, IDX_MODE, 8'h03);
    repeat (2) @(posedge mclk);
    chk({po.ss_n, poe.ss_n}, 2'b11);
    wb(1'b1, IDX_MODE, 8'h02);
    repeat (2) @(posedge mclk);
    chk({po.ss_n, poe.ss_n}, 2'b01);
    wb(1'b1, IDX_MODE, 8'h00);
    repeat (2) @(posedge mclk);
    chk(poe.ss_n, 1'b0);
    @(posedge mclk) tb_ss <= 1'b1;
    repeat (2) @(posedge mclk);
    wb(1'b0, IDX_STAT, 8'h00);
    chk(rd[5], 1'b1);
    @(posedge mclk) tb_ss <= 1'b0;
    wb(1'b1, IDX_STAT, 8'h20);
    rdc(IDX_STAT, 8'h01);
    $display("test select pin done");
    wb(1'b1, IDX_DIVL, 8'h04);
    wb(1'b1, IDX_CTRL, 8'hA0);
    repeat (12) @(posedge mclk);
    chk(irq, 1'b1);
    wb(1'b1, IDX_CTRL, 8'h80);
    wb(1'b1, IDX_STAT, 8'h80);
    repeat (12) @(posedge mclk);
    chk(irq, 1'b0);
    wb(1'b1, IDX_CTRL, 8'hA3);
    repeat (12) @(posedge mclk);
    chk(irq, 1'b0);
    $display("test timer done");
    // slave, phase 0, idle-high clock so the undriven sck already sits at idle
    wb(1'b1, IDX_CTRL, 8'h09);
    rnd = nx(rnd);
    wb(1'b1, IDX_DATA, rnd[7:0]);
    @(posedge mclk) tb_ss <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(poe.ss_n, 1'b0);
    for (int b = 7; b >= 0; b--) begin
      tb_mosi <= rnd[8 + b];
      repeat (4) @(posedge mclk);
      srx[b] = pw.miso;
      tb_sck <= 1'b0;
      repeat (4) @(posedge mclk);
      tb_sck <= 1'b1;
    end
    repeat (4) @(posedge mclk);
    chk(srx, rnd[7:0]);
    wb(1'b0, IDX_STAT, 8'h00);
    chk(rd[0], 1'b0);
    wb(1'b0, IDX_DATA, 8'h00);
    chk(rd, rnd[15:8]);
    @(posedge mclk) tb_ss <= 1'b0;
    repeat (3) @(posedge mclk);
    rdc(IDX_STAT, 8'h81);
    wb(1'b1, IDX_STAT, 8'h80);
    wb(1'b1, IDX_CTRL, 8'h40);
    rdc(IDX_STAT, 8'h81);
    rdc(IDX_CTRL, 8'h00);
    $display("test slave done");
    test_done;
  end
endmodule
`default_nettype wire
